// ### dmx_pkg.sv
// Operation
// - Serialise four-to-one with ratio bit low, two-to-one with it high (up to 1.5 GHz).
// - In two-to-one operation ports C and D are ignored and may float.
// - Waveform selector: 00 hold, 01 narrow return-to-zero, 10 half return-to-zero, 11 RF.
// - An unconfigured waveform selector behaves as 11, the RF waveform.
// - Half return-to-zero shows each sample for half the period, zero after.
// - Narrow return-to-zero forces a one-clock zero pulse (75 ps rounded up to one clock) every period.
// - Synchronisation input is active high; the source raises it to request a restart.
// - Sampled-data clock is the master clock divided, factor chosen by two select bits.
// - Phase selector delays the sampled-data clock by value times half a master cycle.
// - Samples are offset binary; 1000000000 is the zero level.
package dmx_pkg;
  localparam int SAMPLE_W   = 10;
  localparam int NUM_PORTS  = 4;
  localparam int WORD_W     = SAMPLE_W * NUM_PORTS;
  localparam int FIFO_DEPTH = 8;
  localparam int AVS_ADDR_W = 4;
  localparam int DIV_W      = 6;

  localparam logic [AVS_ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [AVS_ADDR_W-1:0] STAT_ADDR = 4'h4;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MUX_BIT   = 1;
  localparam int CTRL_MODE_LSB  = 2;
  localparam int CTRL_OCDS_LSB  = 4;
  localparam int CTRL_PSS_LSB   = 6;
  localparam int STAT_UNDER_BIT = 0;
  localparam int STAT_OVER_BIT  = 1;
  localparam int STAT_EMPTY_BIT = 2;

  localparam logic [SAMPLE_W-1:0] MIDSCALE = 10'h200;
  localparam logic                MUX_4TO1 = 1'b0;
  localparam logic                MUX_2TO1 = 1'b1;
  localparam logic [1:0]          LAST_SLOT_4 = 2'h3;
  localparam logic [1:0]          LAST_SLOT_2 = 2'h1;
  // Half period of the sampled-data clock in clock cycles, before the division select
  localparam logic [DIV_W-1:0]    HALF_DIV_4 = 6'h08;
  localparam logic [DIV_W-1:0]    HALF_DIV_2 = 6'h04;

  // A sample lasts two clock cycles, so half a master cycle is one clock
  localparam int CLK_PERIOD_PS = 10000;
  localparam int RESHAPE_PS    = 75;
  localparam int RESHAPE_CYC   = (RESHAPE_PS / CLK_PERIOD_PS) < 1 ? 1 : RESHAPE_PS / CLK_PERIOD_PS;
  localparam int MAX_2TO1_MHZ  = 1500;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_NRTZ = 2'b01,
    MODE_RTZ  = 2'b10,
    MODE_RF   = 2'b11
  } dmx_mode_type;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_RUN  = 2'b10
  } dmx_ser_state_type;

  typedef struct packed {
    logic [2:0]   pss;
    logic [1:0]   ocds;
    dmx_mode_type mode;
    logic         mux_ratio;
    logic         enable;
  } dmx_ctrl_type;

  typedef logic [NUM_PORTS-1:0][SAMPLE_W-1:0] dmx_port_word_type;

  typedef struct packed {
    logic [SAMPLE_W-1:0] code;
    logic                zero_pulse;
    logic                sample_strobe;
  } dmx_dac_out_type;

  localparam dmx_ctrl_type CTRL_RESET = '{pss: 3'h0, ocds: 2'h0, mode: MODE_RF, mux_ratio: MUX_4TO1, enable: 1'b0};
endpackage

// ### dmx_sync2.sv
`timescale 1ns/1ps
module dmx_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dmx_sync_state_type;

  dmx_sync_state_type s_q;
  dmx_sync_state_type s_d;

  always_comb
  begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q = s_q.s2;
endmodule

// ### dmx_fifo.sv
`timescale 1ns/1ps
module dmx_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wptr;
    logic [PTR_W-1:0]            rptr;
    logic [CNT_W-1:0]            count;
  } dmx_fifo_state_type;

  dmx_fifo_state_type s_q;
  dmx_fifo_state_type s_d;
  logic               push;
  logic               pop;

  assign in_ready  = s_q.count != CNT_FULL;
  assign out_valid = s_q.count != '0;
  assign out_data  = s_q.mem[s_q.rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr = (s_q.wptr == PTR_LAST) ? '0 : s_q.wptr + 1'b1;
    end
    if (pop)
      s_d.rptr = (s_q.rptr == PTR_LAST) ? '0 : s_q.rptr + 1'b1;
    if (push & ~pop)
      s_d.count = s_q.count + 1'b1;
    else if (pop & ~push)
      s_d.count = s_q.count - 1'b1;
    if (flush)
    begin
      s_d.wptr  = '0;
      s_d.rptr  = '0;
      s_d.count = '0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

// ### dmx_output_ctrl.sv
`timescale 1ns/1ps
module dmx_output_ctrl
  import dmx_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         nrst,
  input  wire logic [dmx_pkg::AVS_ADDR_W-1:0] avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         link_clk_in,
  input  wire dmx_pkg::dmx_port_word_type   port_data,
  input  wire logic                         multi_device_sync_in,
  output dmx_pkg::dmx_dac_out_type          dac_out,
  output logic                              sampled_data_clock_out,
  output logic                              sampled_data_clock_out_n
);
  import dmx_pkg::*;

  typedef struct packed {
    dmx_ctrl_type        ctrl;
    logic                wrote_ctrl;
    logic [31:0]         rdata;
    logic                ack;
    logic                underrun;
    logic                overflow;
    logic                link_prev;
    logic                sync_prev;
    dmx_ser_state_type   st;
    logic [1:0]          slot;
    logic                half;
    dmx_port_word_type   cur;
    logic [SAMPLE_W-1:0] held;
    logic [1:0]          pulse_cnt;
    logic [DIV_W-1:0]    div_cnt;
    logic                dclk;
    logic [6:0]          tap;
    logic                clk_out;
    dmx_dac_out_type     out;
  } dmx_state_type;

  localparam dmx_state_type RESET_STATE = '{
    ctrl:    CTRL_RESET,
    st:      SER_IDLE,
    out:     '{code: MIDSCALE, zero_pulse: 1'b0, sample_strobe: 1'b0},
    default: '0
  };

  dmx_state_type                s_q;
  dmx_state_type                s_d;
  logic [WORD_W+1:0]            pins_s;
  logic                         lk;
  logic                         sy;
  logic                         lk_rise;
  logic                         sy_rise;
  dmx_port_word_type            data_s;
  logic                         push_valid;
  logic                         push_ready;
  dmx_port_word_type            push_data;
  logic                         pop;
  logic                         fifo_valid;
  dmx_port_word_type            fifo_data;
  logic                         req;
  logic [31:0]                  rd_mux;
  logic                         set_under;
  logic                         clr_under;
  logic                         clr_over;
  logic [1:0]                   last_slot;
  logic [DIV_W-1:0]             half_div;
  logic [SAMPLE_W-1:0]          smp;

  // Data, link clock and sync all come from the source's domain
  dmx_sync2 #(
    .WIDTH (WORD_W + 2)
  ) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .d     ({multi_device_sync_in, link_clk_in, port_data}),
    .q     (pins_s)
  );

  assign sy      = pins_s[WORD_W+1];
  assign lk      = pins_s[WORD_W];
  assign data_s  = pins_s[WORD_W-1:0];
  assign lk_rise = lk & ~s_q.link_prev;
  assign sy_rise = sy & ~s_q.sync_prev;

  // Words arrive on the link clock edge; a full buffer drops the word and flags it
  assign push_valid = lk_rise & s_q.ctrl.enable;
  always_comb
  begin
    push_data = data_s;
    if (s_q.ctrl.mux_ratio == MUX_2TO1)
    begin
      push_data[2] = '0;
      push_data[3] = '0;
    end
  end

  dmx_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (sy_rise),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~s_q.ack;
  assign avs_readdata    = s_q.rdata;

  always_comb
  begin
    rd_mux = '0;
    if (avs_address == CTRL_ADDR)
    begin
      rd_mux[CTRL_EN_BIT]                    = s_q.ctrl.enable;
      rd_mux[CTRL_MUX_BIT]                   = s_q.ctrl.mux_ratio;
      rd_mux[CTRL_MODE_LSB+1:CTRL_MODE_LSB]  = s_q.ctrl.mode;
      rd_mux[CTRL_OCDS_LSB+1:CTRL_OCDS_LSB]  = s_q.ctrl.ocds;
      rd_mux[CTRL_PSS_LSB+2:CTRL_PSS_LSB]    = s_q.ctrl.pss;
    end
    else if (avs_address == STAT_ADDR)
    begin
      rd_mux[STAT_UNDER_BIT] = s_q.underrun;
      rd_mux[STAT_OVER_BIT]  = s_q.overflow;
      rd_mux[STAT_EMPTY_BIT] = ~fifo_valid;
    end
  end

  assign last_slot = (s_q.ctrl.mux_ratio == MUX_2TO1) ? LAST_SLOT_2 : LAST_SLOT_4;

  // Longer division only widens the half period by a power of two
  always_comb
  begin
    half_div = (s_q.ctrl.mux_ratio == MUX_2TO1) ? HALF_DIV_2 : HALF_DIV_4;
    case (s_q.ctrl.ocds)
      2'b01:   half_div = half_div << 1;
      2'b10:   half_div = half_div << 2;
      default: half_div = half_div;
    endcase
  end

  always_comb
  begin
    s_d                   = s_q;
    s_d.out.sample_strobe = 1'b0;
    pop                   = 1'b0;
    set_under             = 1'b0;
    smp                   = MIDSCALE;
    clr_under             = 1'b0;
    clr_over              = 1'b0;
    s_d.link_prev         = lk;
    s_d.sync_prev         = sy;

    // One wait state, then the answer stands at the edge that completes it
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack)
      s_d.rdata = rd_mux;
    if (avs_write & s_q.ack)
    begin
      if (avs_address == CTRL_ADDR)
      begin
        s_d.wrote_ctrl     = 1'b1;
        s_d.ctrl.enable    = avs_writedata[CTRL_EN_BIT];
        s_d.ctrl.mux_ratio = avs_writedata[CTRL_MUX_BIT];
        s_d.ctrl.mode      = dmx_mode_type'(avs_writedata[CTRL_MODE_LSB+1:CTRL_MODE_LSB]);
        s_d.ctrl.ocds      = avs_writedata[CTRL_OCDS_LSB+1:CTRL_OCDS_LSB];
        s_d.ctrl.pss       = avs_writedata[CTRL_PSS_LSB+2:CTRL_PSS_LSB];
      end
      else if (avs_address == STAT_ADDR)
      begin
        clr_under = avs_writedata[STAT_UNDER_BIT];
        clr_over  = avs_writedata[STAT_OVER_BIT];
      end
    end

    if (s_q.pulse_cnt != 2'h0)
      s_d.pulse_cnt = s_q.pulse_cnt - 2'h1;

    unique case (s_q.st)
      SER_IDLE:
      begin
        s_d.half     = 1'b0;
        s_d.slot     = 2'h0;
        s_d.out.code = MIDSCALE;
        if (s_q.ctrl.enable)
          s_d.st = SER_RUN;
      end
      SER_RUN:
      begin
        if (!s_q.ctrl.enable)
          s_d.st = SER_IDLE;
        else if (!s_q.half)
        begin
          // A new word is fetched only at slot 0, so ports never mix across words
          if (s_q.slot == 2'h0)
          begin
            if (fifo_valid)
            begin
              pop     = 1'b1;
              smp     = fifo_data[0];
              s_d.cur = fifo_data;
            end
            else
              set_under = 1'b1;
          end
          else
            smp = s_q.cur[s_q.slot];
          if (!set_under)
            s_d.slot = (s_q.slot == last_slot) ? 2'h0 : s_q.slot + 2'h1;
          s_d.held              = smp;
          s_d.out.code          = smp;
          s_d.out.sample_strobe = 1'b1;
          if (s_q.ctrl.mode == MODE_NRTZ)
            s_d.pulse_cnt = 2'(RESHAPE_CYC);
          else
            s_d.pulse_cnt = 2'h0;
          s_d.half = 1'b1;
        end
        else
        begin
          s_d.half = 1'b0;
          unique case (s_q.ctrl.mode)
            MODE_HOLD: s_d.out.code = s_q.held;
            MODE_NRTZ: s_d.out.code = s_q.held;
            MODE_RTZ:  s_d.out.code = MIDSCALE;
            MODE_RF:   s_d.out.code = ~s_q.held;
          endcase
        end
      end
    endcase

    // Sampled-data clock divider and half-cycle phase taps
    if (!s_q.ctrl.enable)
    begin
      s_d.div_cnt = '0;
      s_d.dclk    = 1'b0;
    end
    else if (s_q.div_cnt >= half_div - 6'h01)
    begin
      s_d.div_cnt = '0;
      s_d.dclk    = ~s_q.dclk;
    end
    else
      s_d.div_cnt = s_q.div_cnt + 6'h01;
    s_d.tap = {s_q.tap[5:0], s_q.dclk};
    s_d.clk_out = (s_q.ctrl.pss == 3'h0) ? s_q.dclk : s_q.tap[3'(s_q.ctrl.pss - 3'h1)];

    // Restart pulls the divider and the serialiser back to a common phase
    if (sy_rise)
    begin
      s_d.div_cnt = '0;
      s_d.dclk    = 1'b0;
      s_d.half    = 1'b0;
      s_d.slot    = 2'h0;
    end

    // Set wins over a clear in the same cycle
    s_d.underrun       = (s_q.underrun & ~clr_under) | set_under;
    s_d.overflow       = (s_q.overflow & ~clr_over) | (push_valid & ~push_ready);
    s_d.out.zero_pulse = s_d.pulse_cnt != 2'h0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s_q <= RESET_STATE;
    else
      s_q <= s_d;
  end

  assign dac_out                  = s_q.out;
  assign sampled_data_clock_out   = s_q.clk_out;
  assign sampled_data_clock_out_n = ~s_q.clk_out;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence dclk_high_run;
    s_q.dclk [*4] ##1 !s_q.dclk;
  endsequence

  sequence second_half_step(dmx_mode_type m);
    s_q.st == SER_RUN && s_q.ctrl.enable && s_q.half && s_q.ctrl.mode == m && !sy_rise;
  endsequence

  property div_two_to_one;
    disable iff (!nrst || sy_rise || avs_write)
    $rose(s_q.dclk) && s_q.ctrl.mux_ratio == MUX_2TO1 && s_q.ctrl.ocds == 2'b00 |-> dclk_high_run;
  endproperty

  chk_mode_default: assert property (!s_q.wrote_ctrl |-> s_q.ctrl.mode == MODE_RF)
    else $error("waveform selector not RF before first write");
  chk_rtz_zero_half: assert property (second_half_step(MODE_RTZ) |=> s_q.out.code == MIDSCALE)
    else $error("half return-to-zero did not output zero level");
  chk_hold_keep: assert property (second_half_step(MODE_HOLD) |=> $stable(s_q.out.code))
    else $error("hold waveform changed within a sample");
  chk_rf_mirror: assert property (second_half_step(MODE_RF) |=> s_q.out.code == ~$past(s_q.out.code))
    else $error("RF waveform second half not mirrored");
  chk_nrtz_pulse: assert property (s_q.out.zero_pulse == (s_q.out.sample_strobe && $past(s_q.ctrl.mode) == MODE_NRTZ))
    else $error("reshaping pulse not aligned to sample start");
  chk_div_period: assert property (div_two_to_one)
    else $error("sampled-data clock half period wrong");
  chk_pss_delay: assert property ($past(s_q.ctrl.pss) == 3'h3 |-> s_q.clk_out == $past(s_q.dclk, 4))
    else $error("phase select delay wrong");
  chk_sync_restart: assert property (sy_rise |=> s_q.div_cnt == '0 && !s_q.dclk && !s_q.half && s_q.slot == 2'h0)
    else $error("sync did not restart divider and serialiser");
  chk_pop_slot_zero: assert property (pop |-> s_q.slot == 2'h0 && !s_q.half ##1 s_q.out.sample_strobe)
    else $error("word fetched away from first slot");
  chk_slot_range: assert property (s_q.ctrl.mux_ratio == MUX_2TO1 && $past(s_q.ctrl.mux_ratio) == MUX_2TO1
                                   && $past(s_q.slot) <= LAST_SLOT_2 |-> s_q.slot <= LAST_SLOT_2)
    else $error("two-to-one used more than two slots");
  chk_cd_ignored: assert property (push_valid && s_q.ctrl.mux_ratio == MUX_2TO1 |-> push_data[3] == '0 && push_data[2] == '0)
    else $error("ports C and D used in two-to-one");
endmodule

// ### dmx_src_model.sv
`timescale 1ns/1ps
module dmx_src_model
  import dmx_pkg::*;
(
  output logic                      link_clk_in,
  output dmx_pkg::dmx_port_word_type port_data,
  input  wire logic                 half_rate
);
  import dmx_pkg::*;

  dmx_port_word_type word_q[$];
  logic              flip;

  task automatic push(input dmx_port_word_type w);
    word_q.push_back(w);
  endtask

  initial
  begin
    link_clk_in = 1'b0;
    port_data = '0;
    flip = 1'b0;
    // Odd start keeps the link edges off the system clock grid
    #3;
    forever
    begin
      if (word_q.size() == 0)
        #80;
      else
      begin
        port_data = word_q.pop_front();
        flip = ~flip;
        // Unused ports float in half-rate use: drive junk that moves
        if (half_rate)
          port_data[3:2] = {2{10'h155 ^ {10{flip}}}};
        #40 link_clk_in = 1'b1;
        // Hold time over: stale data must never be taken
        #30 port_data = ~port_data;
        #10 link_clk_in = 1'b0;
      end
    end
  end
endmodule

// ### dmx_output_ctrl_tb_top.sv
`timescale 1ns/1ps
module dmx_output_ctrl_tb_top;
  import dmx_pkg::*;

  logic                  clock = 1'b0;
  logic                  nrst = 1'b0;
  logic [AVS_ADDR_W-1:0] avs_address = '0;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = '0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  link_clk_in;
  dmx_port_word_type     port_data;
  logic                  multi_device_sync_in = 1'b0;
  dmx_dac_out_type       dac_out;
  logic                  clk_out;
  logic                  clk_out_n;
  logic                  half_rate = 1'b0;
  logic [1:0]            mode_x = 2'h3;
  logic [1:0]            ocds_x = 2'h0;
  logic                  last_lvl;
  logic                  h1_due = 1'b0;
  logic [9:0]            h0_code;
  logic [9:0]            exp_q[$];
  logic [9:0]            corner [4] = '{10'h000, 10'h3FF, 10'h1FF, 10'h201};
  logic [31:0]           rd;
  integer                seed = 32'h592331dc;
  int                    errors = 0;
  int                    checked = 0;
  int                    hp_cnt = 0;
  int                    skip_n = 3;

  always #5 clock = ~clock;

  dmx_output_ctrl dut (
    .clock                    (clock),
    .nrst                     (nrst),
    .avs_address              (avs_address),
    .avs_read                 (avs_read),
    .avs_write                (avs_write),
    .avs_writedata            (avs_writedata),
    .avs_readdata             (avs_readdata),
    .avs_waitrequest          (avs_waitrequest),
    .link_clk_in              (link_clk_in),
    .port_data                (port_data),
    .multi_device_sync_in     (multi_device_sync_in),
    .dac_out                  (dac_out),
    .sampled_data_clock_out   (clk_out),
    .sampled_data_clock_out_n (clk_out_n)
  );

  dmx_src_model src (
    .link_clk_in (link_clk_in),
    .port_data   (port_data),
    .half_rate   (half_rate)
  );

  task automatic check(input logic ok, input string msg);
    checked++;
    if (!ok)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic int exp_half(input logic hr, input logic [1:0] oc);
    return 2 * (hr ? 2 : 4) * (oc == 2'h1 ? 2 : (oc == 2'h2 ? 4 : 1));
  endfunction

  function automatic logic [9:0] second_half(input logic [1:0] md, input logic [9:0] c);
    case (md)
      2'h2: return MIDSCALE;
      2'h3: return ~c;
      default: return c;
    endcase
  endfunction

  task automatic avs_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest and read data are taken at the rising edge that completes the transfer
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50)
      check(1'b0, "bus answer missing");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic set_ctrl(input logic en, input logic hr, input logic [1:0] md, input logic [1:0] oc);
    avs_xfer(1'b1, CTRL_ADDR, {23'h0, 3'($random(seed)), oc, md, hr, en}, rd);
    mode_x = md;
    ocds_x = oc;
    half_rate = hr;
    skip_n = 3;
  endtask

  task automatic stream(input int nw);
    dmx_port_word_type w;
    int i;
    int k;
    int t;
    for (i = 0; i < nw; i++)
    begin
      for (k = 0; k < NUM_PORTS; k++)
      begin
        w[k] = (i == 0) ? corner[k] : 10'($random(seed));
        if (w[k] === MIDSCALE)
          w[k] = 10'h201;
        if (k < (half_rate ? 2 : 4))
          exp_q.push_back(w[k]);
      end
      src.push(w);
    end
    t = 0;
    while (exp_q.size() != 0 && t < nw * 16 + 200)
    begin
      @(posedge clock);
      t++;
    end
    check(exp_q.size() == 0, "samples missing at output");
    repeat (150) @(posedge clock);
  endtask

  always @(negedge clock)
  begin
    if (nrst)
    begin
      check(clk_out_n === ~clk_out, "clock pair not complementary");
      hp_cnt++;
      if (clk_out !== last_lvl)
      begin
        if (skip_n > 0)
          skip_n--;
        else
          check(hp_cnt == exp_half(half_rate, ocds_x), "data clock half period");
        hp_cnt = 0;
      end
      last_lvl = clk_out;
      if (h1_due)
      begin
        check(dac_out.code === second_half(mode_x, h0_code), "second half of sample");
        check(dac_out.zero_pulse === 1'b0, "reshape pulse too long");
      end
      h1_due = 1'b0;
      if (dac_out.sample_strobe === 1'b1 && dac_out.code !== MIDSCALE)
      begin
        check(exp_q.size() != 0 && dac_out.code === exp_q[0], "sample value or order");
        if (exp_q.size() != 0)
          void'(exp_q.pop_front());
        check(dac_out.zero_pulse === (mode_x == MODE_NRTZ), "reshape pulse");
        h0_code = dac_out.code;
        h1_due = 1'b1;
      end
    end
  end

  initial
  begin
    #200000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    avs_xfer(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd === 32'h0000000C, "control reset value");
    avs_xfer(1'b1, 4'h8, 32'hFFFFFFFF, rd);
    avs_xfer(1'b0, 4'h8, 32'h0, rd);
    check(rd === 32'h0, "unmapped read");
    avs_xfer(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd === 32'h0000000C, "unmapped write leaked");
    for (int m = 0; m < 4; m++)
    begin
      set_ctrl(1'b1, MUX_4TO1, 2'(m), 2'(m));
      stream(12);
    end
    set_ctrl(1'b1, MUX_2TO1, 2'($random(seed)), 2'h1);
    stream(10);
    set_ctrl(1'b0, MUX_2TO1, 2'h0, 2'h0);
    avs_xfer(1'b0, STAT_ADDR, 32'h0, rd);
    check(rd[STAT_UNDER_BIT] === 1'b1 && rd[STAT_EMPTY_BIT] === 1'b1, "underrun and empty status");
    avs_xfer(1'b1, STAT_ADDR, 32'h1, rd);
    avs_xfer(1'b0, STAT_ADDR, 32'h0, rd);
    check(rd === 32'h4, "status after clear");
    set_ctrl(1'b1, MUX_4TO1, 2'h0, 2'h0);
    multi_device_sync_in <= 1'b1;
    repeat (4) @(posedge clock);
    multi_device_sync_in <= 1'b0;
    skip_n = 3;
    stream(8);
    end_of_test();
  end
endmodule
